// *** msr_pkg.sv ***
// Constants, register map and types for the message start/retry scheduler
// Summary of operation
// R1: Mask identifier Johnson counter steps only when the 3-bit reject accumulator overflows.
// R2: Bit 0 of the decoded 12-bit backoff mask is always set.
// R3: First attempt loads identifier low five bits from the initial field, top bit zero.
// R4: Identifier 100000 stepping again wraps to 000000, the smallest mask.
// R5: Backoff counter releases on passing zero to minus one: N gives N+1 intervals.
// R6: Software writes only legal Johnson states into the initial mask field.
// R7: Slotted messages wait for their slot, then start or retry.
// R8: Two 8-bit slot sets: immediate bit 7, period bits 6..5, phase bits 4..0.
// R9: Period code 00 gives 4.0 us, 01 2.0 us, 10 1.0 us, 11 0.5 us.
// R10: Slot immediate bit starts the first attempt at once; retries always compare.
// R11: Slot active when {rtc low 1..0, prescaler 5..0} matches phase and period zeros.
// R12: Software keeps slot phase no larger than the prescaler low five-bit terminal.
// R13: Comparison rtc bits step on the prescaler 000000 to 000001 transition.
// R14: Each message gets one of four classes from lock bit and request type bits.
// R15: Class 00 slot set a, 01 slot set b, 10 backoff a, 11 backoff b.
// R16: A 16-bit map of eight 2-bit fields classes each request encoding.
// R17: Force-sync bypasses the map, classes the message 00, uses slot set a.
// R18: Two 8-bit backoff sets: immediate bit 7, initial id 6..2, step 1..0.
// R19: Backoff immediate bit starts the first attempt at once; retries use backoff.
// R20: Each new backoff-class message clears the accumulator and reloads the identifier.
package msr_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;
   // Register map, word offsets
   localparam logic [3:0] REG_TX_TIME   = 4'h0;
   localparam logic [3:0] REG_CLASS_MAP = 4'h1;
   localparam logic [3:0] REG_STATUS    = 4'h2;
   localparam logic [31:0] TX_TIME_RESET   = 32'h0000_0000;
   localparam logic [15:0] CLASS_MAP_RESET = 16'h0000;
   // Byte lanes of the transmit time register
   localparam int unsigned SLOT_A_LSB = 0;
   localparam int unsigned SLOT_B_LSB = 8;
   localparam int unsigned BACK_A_LSB = 16;
   localparam int unsigned BACK_B_LSB = 24;
   // Fields inside a parameter byte
   localparam int unsigned IMM_BIT    = 7;
   localparam int unsigned PER_MSB    = 6;
   localparam int unsigned PER_LSB    = 5;
   localparam int unsigned PHASE_MSB  = 4;
   localparam int unsigned INIT_MSB   = 6;
   localparam int unsigned INIT_LSB   = 2;
   localparam int unsigned STEP_MSB   = 1;
   // Slot period codes
   localparam logic [1:0] PER_4US0 = 2'h0;
   localparam logic [1:0] PER_2US0 = 2'h1;
   localparam logic [1:0] PER_1US0 = 2'h2;
   localparam logic [1:0] PER_0US5 = 2'h3;
   localparam int unsigned MASK_W  = 12;
   localparam int unsigned ID_W    = 6;
   localparam int unsigned ACC_W   = 3;
   localparam logic [5:0]  ID_LAST = 6'h20;
   localparam logic [11:0] LFSR_SEED = 12'hACE;
   localparam logic [5:0]  PRESC_ZERO = 6'h00;
   localparam logic [5:0]  PRESC_ONE  = 6'h01;

   typedef enum logic [1:0] {
      CLS_SLOT_A = 2'b00,
      CLS_SLOT_B = 2'b01,
      CLS_BACK_A = 2'b10,
      CLS_BACK_B = 2'b11
   } msr_class_t;

   typedef enum logic [2:0] {
      ST_IDLE         = 3'b000,
      ST_LOAD         = 3'b001,
      ST_WAIT_BACKOFF = 3'b010,
      ST_WAIT_SLOT    = 3'b011,
      ST_SENT         = 3'b100
   } msr_state_t;
endpackage

// *** msr_slot_match.sv ***
// Slot arrival comparator for one slot parameter set
module msr_slot_match (
   input  wire logic [7:0] slot_set_i,
   input  wire logic [7:0] time_i,
   output logic            hit_o
);
   logic [1:0] per;
   logic [2:0] upper_care;
   logic       phase_eq;

   assign per = slot_set_i[msr_pkg::PER_MSB:msr_pkg::PER_LSB];
   assign phase_eq = time_i[msr_pkg::PHASE_MSB:0]
                     == slot_set_i[msr_pkg::PHASE_MSB:0];

   // R9: period code selection
   always_comb begin
      unique case (per)
         msr_pkg::PER_4US0: upper_care = 3'h7;
         msr_pkg::PER_2US0: upper_care = 3'h3;
         msr_pkg::PER_1US0: upper_care = 3'h1;
         msr_pkg::PER_0US5: upper_care = 3'h0;
      endcase
   end

   // R11: masked compare against zeros
   assign hit_o = phase_eq && ((time_i[7:5] & upper_care) == 3'h0);
endmodule // msr_slot_match

// *** msr_backoff_mask.sv ***
// Backoff mask identifier Johnson counter, reject accumulator and decode
module msr_backoff_mask (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        load_i,
   input  wire logic [4:0]  init_i,
   input  wire logic        step_i,
   input  wire logic [1:0]  step_const_i,
   output logic [11:0]      mask_o,
   output logic [5:0]       mask_id_o,
   output logic [2:0]       acc_o
);
   logic [5:0] id_reg;
   logic [2:0] acc_reg;
   logic [3:0] sum;
   logic       ovf;
   logic [2:0] ones;
   logic [3:0] top;

   assign sum = {1'b0, acc_reg} + {2'h0, step_const_i};
   assign ovf = sum[3];

   // R20: clear accumulator on new message
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_reg <= 3'h0;
      end else if (load_i) begin
         acc_reg <= 3'h0;
      end else if (step_i) begin
         acc_reg <= sum[2:0];
      end
   end

   // R1: step on overflow only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         id_reg <= 6'h00;
      end else if (load_i) begin
         // R3: top bit forced to zero
         id_reg <= {1'b0, init_i};
      end else if (step_i && ovf) begin
         // R4: Johnson step wraps 100000 to 000000
         id_reg <= {id_reg[4:0], ~id_reg[5]};
      end
   end

   always_comb begin
      ones = 3'h0;
      for (int i = 0; i < 6; i++) begin
         ones = ones + {2'h0, id_reg[i]};
      end
   end
   assign top = id_reg[5] ? 4'(12 - int'(ones)) : {1'b0, ones};

   // R2: decode keeps bit 0 set
   for (genvar g = 0; g < msr_pkg::MASK_W; g++) begin : g_mask
      assign mask_o[g] = (g <= int'(top));
   end

   assign mask_id_o = id_reg;
   assign acc_o     = acc_reg;

   property p_mask_lsb;
      @(posedge clk_i) disable iff (rst_i) mask_o[0];
   endproperty
   a_mask_lsb: assert property (p_mask_lsb) // R2
      else $error("backoff mask bit 0 cleared");

   property p_step_needs_ovf;
      @(posedge clk_i) disable iff (rst_i)
         !load_i && !(step_i && ovf) |=> $stable(id_reg);
   endproperty
   a_step_needs_ovf: assert property (p_step_needs_ovf) // R1
      else $error("identifier moved without accumulator overflow");

   property p_init_load;
      @(posedge clk_i) disable iff (rst_i)
         load_i |=> id_reg == {1'b0, $past(init_i)} && acc_reg == 3'h0;
   endproperty
   a_init_load: assert property (p_init_load) // R3
      else $error("identifier not loaded from initial field");

   property p_wrap;
      @(posedge clk_i) disable iff (rst_i)
         !load_i && step_i && ovf && id_reg == msr_pkg::ID_LAST
         |=> id_reg == 6'h00 && mask_o == 12'h001;
   endproperty
   a_wrap: assert property (p_wrap) // R4
      else $error("identifier did not wrap to smallest mask");
endmodule // msr_backoff_mask

// *** msr_scheduler.sv ***
// Initial message start/retry scheduler with register port
module msr_scheduler #(
   parameter logic [11:0] LFSR_INIT = msr_pkg::LFSR_SEED
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [31:0]      rdata_o,
   input  wire logic        req_i,
   input  wire logic        lock_operation_bits_i,
   input  wire logic [1:0]  request_type_bits_i,
   input  wire logic        force_sync_i,
   input  wire logic        reject_i,
   input  wire logic        done_i,
   input  wire logic [5:0]  time_prescaler_i,
   output logic             start_o,
   output logic             busy_o,
   output logic [1:0]       class_o
);
   if (LFSR_INIT == 12'h000) begin : g_chk
      $error("LFSR_INIT must be nonzero");
   end

   msr_pkg::msr_state_t state_reg;
   msr_pkg::msr_state_t state_next;
   msr_pkg::msr_class_t class_reg;
   msr_pkg::msr_class_t class_next;
   logic [31:0] tx_time_reg;
   logic [15:0] class_map_reg;
   logic [31:0] rdata_reg;
   logic [11:0] lfsr_reg;
   logic [11:0] cnt_reg;
   logic [5:0]  presc_prev_reg;
   logic [1:0]  slot_rtc_reg;
   logic [1:0]  slot_rtc_now;
   logic        rtc_step;
   logic [7:0]  slot_time;
   logic [7:0]  slot_a;
   logic [7:0]  slot_b;
   logic [7:0]  back_a;
   logic [7:0]  back_b;
   logic [7:0]  slot_sel;
   logic [7:0]  back_sel;
   logic [7:0]  slot_first;
   logic [7:0]  back_first;
   logic [2:0]  req_code;
   logic        hit;
   logic        first_imm;
   logic        load_mask;
   logic        step;
   logic        slot_go;
   logic        back_go;
   logic [11:0] mask;
   logic [5:0]  mask_id;
   logic [2:0]  acc;

   // R8: parameter sets as byte lanes
   assign slot_a = tx_time_reg[msr_pkg::SLOT_A_LSB +: 8];
   assign slot_b = tx_time_reg[msr_pkg::SLOT_B_LSB +: 8];
   // R18: backoff sets as byte lanes
   assign back_a = tx_time_reg[msr_pkg::BACK_A_LSB +: 8];
   assign back_b = tx_time_reg[msr_pkg::BACK_B_LSB +: 8];

   // Register writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_time_reg <= msr_pkg::TX_TIME_RESET;
      end else if (wr_i && addr_i == msr_pkg::REG_TX_TIME) begin
         tx_time_reg <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         class_map_reg <= msr_pkg::CLASS_MAP_RESET;
      end else if (wr_i && addr_i == msr_pkg::REG_CLASS_MAP) begin
         class_map_reg <= wdata_i[15:0];
      end
   end

   // Read data valid the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (rd_i) begin
         unique case (addr_i)
            msr_pkg::REG_TX_TIME:   rdata_reg <= tx_time_reg;
            msr_pkg::REG_CLASS_MAP: rdata_reg <= {16'h0000, class_map_reg};
            msr_pkg::REG_STATUS:    rdata_reg <= {18'h00000, acc, mask_id,
                                                  class_reg, state_reg};
            default:                rdata_reg <= 32'h0000_0000;
         endcase
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end
   assign rdata_o = rdata_reg;

   // Random source for the backoff load
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lfsr_reg <= LFSR_INIT;
      end else begin
         lfsr_reg <= {lfsr_reg[10:0],
                      lfsr_reg[11] ^ lfsr_reg[10] ^ lfsr_reg[9]
                      ^ lfsr_reg[3]};
      end
   end

   // R13: rtc bits step together with the prescaler 0 to 1 edge
   assign rtc_step = presc_prev_reg == msr_pkg::PRESC_ZERO
                     && time_prescaler_i == msr_pkg::PRESC_ONE;
   assign slot_rtc_now = slot_rtc_reg + {1'b0, rtc_step};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         presc_prev_reg <= msr_pkg::PRESC_ZERO;
         slot_rtc_reg   <= 2'h0;
      end else begin
         presc_prev_reg <= time_prescaler_i;
         slot_rtc_reg   <= slot_rtc_now;
      end
   end
   assign slot_time = {slot_rtc_now, time_prescaler_i};

   // R14: lookup index from lock and request type bits
   assign req_code = {lock_operation_bits_i, request_type_bits_i};

   // R16: map lookup, R17: force-sync bypass
   always_comb begin
      if (force_sync_i) begin
         class_next = msr_pkg::CLS_SLOT_A;
      end else begin
         class_next = msr_pkg::msr_class_t'(class_map_reg[2*req_code +: 2]);
      end
   end

   // R15: class selects the parameter set
   assign slot_sel   = class_reg[0] ? slot_b : slot_a;
   assign back_sel   = class_reg[0] ? back_b : back_a;
   assign slot_first = class_next[0] ? slot_b : slot_a;
   assign back_first = class_next[0] ? back_b : back_a;

   // R10: immediate only on the first attempt; R19 likewise
   assign first_imm = class_next[1] ? back_first[msr_pkg::IMM_BIT]
                                    : slot_first[msr_pkg::IMM_BIT];

   msr_slot_match u_slot (
      .slot_set_i (slot_sel),
      .time_i     (slot_time),
      .hit_o      (hit)
   );

   // R20: new message reloads the mask state
   assign load_mask = state_reg == msr_pkg::ST_IDLE && req_i
                      && class_next[1];
   // Done wins over a reject in the same cycle
   assign step = state_reg == msr_pkg::ST_SENT && reject_i && !done_i
                 && class_reg[1];

   msr_backoff_mask u_mask (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .load_i       (load_mask),
      .init_i       (back_first[msr_pkg::INIT_MSB:msr_pkg::INIT_LSB]),
      .step_i       (step),
      .step_const_i (back_sel[msr_pkg::STEP_MSB:0]),
      .mask_o       (mask),
      .mask_id_o    (mask_id),
      .acc_o        (acc)
   );

   // R7: slot arrival releases a waiting message
   assign slot_go = state_reg == msr_pkg::ST_WAIT_SLOT && hit;
   // R5: release on the step past zero
   assign back_go = state_reg == msr_pkg::ST_WAIT_BACKOFF
                    && cnt_reg == 12'h000;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         msr_pkg::ST_IDLE: begin
            if (req_i) begin
               if (first_imm) begin
                  state_next = msr_pkg::ST_SENT;
               end else if (class_next[1]) begin
                  state_next = msr_pkg::ST_LOAD;
               end else begin
                  state_next = msr_pkg::ST_WAIT_SLOT;
               end
            end
         end
         msr_pkg::ST_LOAD: state_next = msr_pkg::ST_WAIT_BACKOFF;
         msr_pkg::ST_WAIT_BACKOFF: begin
            if (back_go) begin
               state_next = msr_pkg::ST_SENT;
            end
         end
         msr_pkg::ST_WAIT_SLOT: begin
            if (slot_go) begin
               state_next = msr_pkg::ST_SENT;
            end
         end
         msr_pkg::ST_SENT: begin
            if (done_i) begin
               state_next = msr_pkg::ST_IDLE;
            end else if (reject_i) begin
               state_next = class_reg[1] ? msr_pkg::ST_LOAD
                                         : msr_pkg::ST_WAIT_SLOT;
            end
         end
         default: state_next = msr_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= msr_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         class_reg <= msr_pkg::CLS_SLOT_A;
      end else if (state_reg == msr_pkg::ST_IDLE && req_i) begin
         class_reg <= class_next;
      end
   end

   // R5: masked random load, then count down
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= 12'h000;
      end else if (state_reg == msr_pkg::ST_LOAD) begin
         cnt_reg <= lfsr_reg & mask;
      end else if (state_reg == msr_pkg::ST_WAIT_BACKOFF) begin
         cnt_reg <= cnt_reg - 12'h001;
      end
   end

   assign start_o = (state_reg == msr_pkg::ST_IDLE && req_i && first_imm)
                    || slot_go || back_go;
   assign busy_o  = state_reg != msr_pkg::ST_IDLE;
   assign class_o = class_reg;

   sequence s_backoff_loaded;
      state_reg == msr_pkg::ST_LOAD ##1 cnt_reg == 12'h000;
   endsequence

   property p_backoff_zero_release;
      @(posedge clk_i) disable iff (rst_i)
         s_backoff_loaded |-> start_o ##1 state_reg == msr_pkg::ST_SENT;
   endproperty
   a_backoff_zero_release: assert property (p_backoff_zero_release) // R5
      else $error("zero backoff did not release after one interval");

   property p_backoff_count;
      @(posedge clk_i) disable iff (rst_i)
         state_reg == msr_pkg::ST_WAIT_BACKOFF && cnt_reg != 12'h000
         |-> !start_o ##1 (cnt_reg == $past(cnt_reg) - 12'h001
                           && state_reg == msr_pkg::ST_WAIT_BACKOFF);
   endproperty
   a_backoff_count: assert property (p_backoff_count) // R5
      else $error("backoff counter released early or skipped");

   property p_slot_start;
      @(posedge clk_i) disable iff (rst_i)
         state_reg == msr_pkg::ST_WAIT_SLOT |-> start_o == hit;
   endproperty
   a_slot_start: assert property (p_slot_start) // R7
      else $error("slotted start not tied to slot arrival");

   property p_slot_period;
      @(posedge clk_i) disable iff (rst_i)
         slot_go && slot_sel[msr_pkg::PER_MSB:msr_pkg::PER_LSB]
                    == msr_pkg::PER_4US0
         |-> slot_time[7:5] == 3'h0;
   endproperty
   a_slot_period: assert property (p_slot_period) // R9
      else $error("4.0 us slot matched with upper bits set");

   property p_retry_not_immediate;
      @(posedge clk_i) disable iff (rst_i)
         state_reg == msr_pkg::ST_SENT && reject_i && !done_i
         |-> !start_o ##1 (state_reg == msr_pkg::ST_LOAD
                           || state_reg == msr_pkg::ST_WAIT_SLOT);
   endproperty
   a_retry_not_immediate: assert property (p_retry_not_immediate) // R10
      else $error("retry started without slot or backoff");

   property p_rtc_step;
      @(posedge clk_i) disable iff (rst_i)
         !$stable(slot_rtc_reg)
         |-> $past(presc_prev_reg) == msr_pkg::PRESC_ZERO
             && presc_prev_reg == msr_pkg::PRESC_ONE;
   endproperty
   a_rtc_step: assert property (p_rtc_step) // R13
      else $error("rtc bits stepped off the 0 to 1 prescaler edge");

   property p_force_sync;
      @(posedge clk_i) disable iff (rst_i)
         state_reg == msr_pkg::ST_IDLE && req_i && force_sync_i
         |=> class_o == msr_pkg::CLS_SLOT_A;
   endproperty
   a_force_sync: assert property (p_force_sync) // R17
      else $error("force-sync request not classed 00");

   property p_class_lookup;
      @(posedge clk_i) disable iff (rst_i)
         state_reg == msr_pkg::ST_IDLE && req_i && !force_sync_i
         |=> class_o == $past(class_map_reg[2*req_code +: 2]);
   endproperty
   a_class_lookup: assert property (p_class_lookup) // R16
      else $error("class not taken from the map field");
endmodule // msr_scheduler

// *** msr_switch_model.sv ***
// Behavioural switch transmit path that answers each start
module msr_switch_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       start_i,
   input  wire logic [4:0] rejects_i,
   input  wire logic [3:0] delay_i,
   output logic            reject_o,
   output logic            done_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       pend_reg;
   logic [3:0] wait_reg;
   logic [4:0] nrej_reg;
   // Rejects each message rejects_i times, then accepts it
   always_ff @(posedge clk_i) begin
      reject_o <= 1'b0;
      done_o   <= 1'b0;
      if (rst_i) begin
         pend_reg <= 1'b0;
         wait_reg <= 4'h0;
         nrej_reg <= 5'h00;
      end else if (start_i) begin
         pend_reg <= 1'b1;
         wait_reg <= delay_i;
      end else if (pend_reg && wait_reg != 4'h0) begin
         wait_reg <= wait_reg - 4'h1;
      end else if (pend_reg) begin
         pend_reg <= 1'b0;
         if (nrej_reg < rejects_i) begin
            reject_o <= 1'b1;
            nrej_reg <= nrej_reg + 5'h01;
         end else begin
            done_o   <= 1'b1;
            nrej_reg <= 5'h00;
         end
      end
   end
endmodule // msr_switch_model

// *** msr_scheduler_test.sv ***
// Self-checking bench for the message start/retry scheduler
`define MSR_CHK(nm, ex, got) check_val(nm, ex, got)
module msr_scheduler_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [3:0]  addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic        req_i = 1'b0;
   logic        lock_operation_bits_i = 1'b0;
   logic [1:0]  request_type_bits_i = 2'h0;
   logic        force_sync_i = 1'b0;
   logic        reject_i;
   logic        done_i;
   logic [5:0]  time_prescaler_i = 6'h00;
   logic        start_o;
   logic        busy_o;
   logic [1:0]  class_o;
   logic [4:0]  rej_n = 5'h00;
   logic [3:0]  ans_dly = 4'h0;
   logic [31:0] tx_shadow = 32'h0;
   logic [31:0] st;
   logic [1:0]  rtc = 2'h0;
   logic [1:0]  cls;
   logic [5:0]  exp_id;
   logic [2:0]  exp_acc;
   logic [3:0]  acc_sum;
   logic [15:0] cmap = 16'hE41B;
   logic [3:0]  addrs [4] = '{4'h0, 4'h1, 4'h2, 4'hF};
   int          fail_count = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   int          slot_starts = 0;
   int          i, a, k;

   msr_scheduler uut (
      .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .req_i(req_i),
      .lock_operation_bits_i(lock_operation_bits_i),
      .request_type_bits_i(request_type_bits_i),
      .force_sync_i(force_sync_i), .reject_i(reject_i), .done_i(done_i),
      .time_prescaler_i(time_prescaler_i), .start_o(start_o),
      .busy_o(busy_o), .class_o(class_o)
   );
   msr_switch_model sw_model (
      .clk_i(clk_i), .rst_i(rst_i), .start_i(start_o),
      .rejects_i(rej_n), .delay_i(ans_dly),
      .reject_o(reject_i), .done_o(done_i)
   );

   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   // rtc steps on prescaler 0 to 1
   always @(posedge clk_i) begin
      time_prescaler_i <= time_prescaler_i + 6'h01;
      if (rst_i)
         rtc <= 2'h0;
      else if (time_prescaler_i == 6'h00)
         rtc <= rtc + 2'h1;
   end

   always @(posedge clk_i) begin
      if ((req_i && !busy_o) || reject_i)
         cyc <= 1;
      else
         cyc <= cyc + 1;
   end

   function automatic logic slot_hit(input logic [7:0] s);
      logic [7:0] t;
      logic       ok;
      t = {rtc, time_prescaler_i};
      case (s[6:5])
         2'h0: ok = (t[7:5] == 3'h0);
         2'h1: ok = (t[6:5] == 2'h0);
         2'h2: ok = (t[5] == 1'b0);
         default: ok = 1'b1;
      endcase
      return ok && (t[4:0] == s[4:0]);
   endfunction

   always @(negedge clk_i) begin
      if (start_o === 1'b1 && req_i !== 1'b1 && class_o[1] === 1'b0) begin
         slot_starts++;
         `MSR_CHK("slot_hit", 1'b1, slot_hit(tx_shadow[8*class_o[0] +: 8]));
      end
   end

   task automatic check_val(input string nm, input logic [31:0] ex, got);
      samples_checked++;
      if (got !== ex) begin
         fail_count++;
         $display("[ERR] %s expected %0h seen %0h", nm, ex, got);
      end
   endtask

   task automatic reg_write(input logic [3:0] ad, input logic [31:0] d);
      @(posedge clk_i);
      addr_i  <= ad;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      if (ad == msr_pkg::REG_TX_TIME)
         tx_shadow = d;
   endtask

   task automatic reg_read(input logic [3:0] ad, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= ad;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      d = rdata_o;
   endtask

   task automatic send_msg(input logic [2:0] n, input logic fs, imm);
      @(posedge clk_i);
      req_i                 <= 1'b1;
      lock_operation_bits_i <= n[2];
      request_type_bits_i   <= n[1:0];
      force_sync_i          <= fs;
      @(negedge clk_i);
      `MSR_CHK("start_now", imm, start_o);
      @(posedge clk_i);
      req_i <= 1'b0;
      @(negedge clk_i);
      `MSR_CHK("busy", 1'b1, busy_o);
   endtask

   task automatic wait_idle();
      for (int j = 0; j < 6000 && busy_o !== 1'b0; j++)
         @(negedge clk_i);
      `MSR_CHK("idle", 1'b0, busy_o);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk_i);
      fail_count++;
      tally_and_finish();
   end

   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 8; i++) begin
         if (i == 4)
            reg_write(4'h2, 32'hFFFF_FFFF);
         if (i == 4)
            reg_write(4'hF, 32'hFFFF_FFFF);
         reg_read(addrs[i % 4], st);
         `MSR_CHK("reset_or_ro", 32'h0, st);
      end
      reg_write(msr_pkg::REG_TX_TIME, 32'h0081_73F3);
      reg_read(msr_pkg::REG_TX_TIME, st);
      `MSR_CHK("tx_time", 32'h0081_73F3, st);
      reg_write(msr_pkg::REG_CLASS_MAP, {16'h0, cmap});
      reg_read(msr_pkg::REG_CLASS_MAP, st);
      `MSR_CHK("class_map", {16'h0, cmap}, st);
      rej_n = 5'd1;
      for (i = 0; i < 9; i++) begin
         cls = (i == 8) ? 2'h0 : cmap[2*i +: 2];
         send_msg(3'(i), i == 8, cls[0] == 1'b0);
         `MSR_CHK("class", cls, class_o);
         wait_idle();
      end
      ans_dly = 4'd9;
      for (i = 0; i < 4; i++) begin
         reg_write(msr_pkg::REG_TX_TIME, {24'h0, 1'b0, 2'(i), 5'h13});
         send_msg(3'h3, 1'b1, 1'b0);
         wait_idle();
      end
      `MSR_CHK("slot_starts", 32'd15, slot_starts);
      reg_write(msr_pkg::REG_CLASS_MAP, 32'h0000_AAAA);
      reg_write(msr_pkg::REG_TX_TIME, 32'h007F_0000);
      rej_n <= 5'd19;
      ans_dly <= 4'd6;
      exp_id = 6'h1F;
      exp_acc = 3'h0;
      send_msg(3'h0, 1'b0, 1'b0);
      for (a = 0; a < 20; a++) begin
         for (i = 0; i < 5000 && start_o !== 1'b1; i++)
            @(negedge clk_i);
         k = exp_id[5] ? 12 - $countones(exp_id) : $countones(exp_id);
         `MSR_CHK("lat", 1'b1, cyc >= 2 && cyc <= 1 + (2 << k));
         reg_read(msr_pkg::REG_STATUS, st);
         `MSR_CHK("state", 3'h4, st[2:0]);
         `MSR_CHK("mask_id", exp_id, st[10:5]);
         `MSR_CHK("accum", exp_acc, st[13:11]);
         acc_sum = {1'b0, exp_acc} + 4'h3;
         exp_acc = acc_sum[2:0];
         if (acc_sum[3])
            exp_id = {exp_id[4:0], ~exp_id[5]};
      end
      wait_idle();
      tally_and_finish();
   end
endmodule // msr_scheduler_test
